// *** rtl/odac_pkg.sv ***
// Shared constants and types of the octal converter two-wire command port
package odac_pkg;
	// ==========================================================
	// Channel and code geometry
	localparam int CH_N = 8;
	localparam int CODE_W = 12;
	localparam logic [11:0] CODE_RST = 12'h000;
	localparam logic [1:0] PD_RST = 2'h0;
	// ==========================================================
	// Bus addressing
	localparam logic [6:0] ADDR_BASE = 7'h48;
	localparam logic [7:0] HS_MASTER_CODE = 8'h08;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LOW_NIB_FIRST = 4'h4;
	// ==========================================================
	// Command byte fields
	localparam logic [3:0] CMD_PWRDN = 4'h4;
	localparam logic [3:0] CMD_WR_LAST = 4'h3;
	localparam logic [3:0] CH_ALL = 4'hF;
	// ==========================================================
	// Update queue word: kind, channel mask, code
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_W = 21;
	localparam int KIND_BIT = 20;
	localparam int MASK_LSB = 12;
	// ==========================================================
	// Receiver states
	typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_MSB, ST_LSB, ST_READ, ST_SKIP} odac_state_t;
endpackage

// *** rtl/odac_i2c_port.sv ***
// Two-wire target command port with clock-crossing update queue
//
// Contract
// - Answer address 1001000 with direction bit
// - Read-back: command byte, repeated start, two bytes
// - Read-back: upper eight bits, then nibble zero-padded
// - Code is upper byte plus upper nibble
// - Repeated data pairs update after each low byte
// - Channel nibble all-ones addresses all channels
// - Never acknowledge the high-speed master code
// - Never drive or stretch the serial clock
// - Address select pin picks bus address
// - Codes are unsigned 12-bit, 0 to 4095
// - Pin held low updates after low-byte acknowledge
// - Command code 0100 is power-down
`timescale 1ns/1ps

// ==========================================================
// Dual-clock queue with gray pointers
module odac_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Filling side
	input wire logic wr_clk,
	input wire logic wr_rstn,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	// Draining side
	input wire logic rd_clk,
	input wire logic rd_rstn,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // Storage, no reset needed
	logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
	logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg; // Pointer synchronisers
	logic [AW:0] wbin_next, rbin_next;
	logic full, empty;

	// Increment sized to the pointer so no bits are padded or dropped
	assign wbin_next = wbin_reg + (AW+1)'(1);
	assign rbin_next = rbin_reg + (AW+1)'(1);
	// Full when write pointer is one lap ahead of read pointer
	assign full = wgray_reg == {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
	assign empty = rgray_reg == wg_s2_reg;
	assign wr_ready = ~full;
	assign rd_valid = ~empty;
	assign rd_data = mem[rbin_reg[AW-1:0]];

	// Write port and write pointer
	always_ff @(posedge wr_clk) begin
		if (wr_valid && wr_ready) begin
			mem[wbin_reg[AW-1:0]] <= wr_data;
		end
	end
	always_ff @(posedge wr_clk or negedge wr_rstn) begin
		if (!wr_rstn) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			rg_s1_reg <= '0;
			rg_s2_reg <= '0;
		end else begin
			rg_s1_reg <= rgray_reg;
			rg_s2_reg <= rg_s1_reg;
			if (wr_valid && wr_ready) begin
				wbin_reg <= wbin_next;
				wgray_reg <= wbin_next ^ (wbin_next >> 1);
			end
		end
	end

	// Read pointer
	always_ff @(posedge rd_clk or negedge rd_rstn) begin
		if (!rd_rstn) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			wg_s1_reg <= '0;
			wg_s2_reg <= '0;
		end else begin
			wg_s1_reg <= wgray_reg;
			wg_s2_reg <= wg_s1_reg;
			if (rd_valid && rd_ready) begin
				rbin_reg <= rbin_next;
				rgray_reg <= rbin_next ^ (rbin_next >> 1);
			end
		end
	end
endmodule

// ==========================================================
// Command port top
module odac_i2c_port (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Link-side oversampling clock
	input wire logic clk_link,
	// Two-wire pins, clock is input only
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps and update pin
	input wire logic [2:0] address_select_pin,
	input wire logic output_update_pin,
	// Channel outputs
	output logic [7:0][11:0] dac_code,
	output logic [7:0][1:0] dac_pd_mode
);
	logic [1:0] lrst_reg; // Link reset release synchroniser
	logic rstn_link;
	logic [2:0] scl_sy_reg, sda_sy_reg, upd_sy_reg;
	logic [2:0] sel_sy_reg [3];
	logic scl_f_reg, sda_f_reg, scl_d_reg, sda_d_reg, upd_f_reg;
	logic [2:0] sel_f_reg;
	logic [6:0] my_addr_reg;
	logic scl_rise, scl_fall, start_det, stop_det;
	odac_pkg::odac_state_t state_reg, after_reg;
	logic in_ack_reg, acked_reg, oe_reg, rd_low_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg, cmd_reg, msb_reg, tx_reg, rd_byte, wr_mask, push_mask;
	logic rx_st, byte_done, addr_hit, is_pd, is_wr, push_fire, wr_ready;
	logic [11:0] shadow_reg [8]; // Link-side copy for read-back
	logic [11:0] rb_code, push_code;
	logic [odac_pkg::FIFO_W-1:0] wr_data, rd_data;
	logic rd_valid, rd_ready, pop;

	// ==========================================================
	// Link domain reset and pin sampling
	always_ff @(posedge clk_link or negedge rstn) begin
		if (!rstn) begin
			lrst_reg <= 2'h0;
		end else begin
			lrst_reg <= {lrst_reg[0], 1'b1};
		end
	end
	assign rstn_link = lrst_reg[1];

	// Three flops per pin; a change counts when stages two and three agree
	always_ff @(posedge clk_link or negedge rstn_link) begin
		if (!rstn_link) begin
			scl_sy_reg <= 3'h7;
			sda_sy_reg <= 3'h7;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sy_reg <= {scl_sy_reg[1:0], scl_in};
			sda_sy_reg <= {sda_sy_reg[1:0], sda_in};
			if (scl_sy_reg[1] == scl_sy_reg[2]) begin
				scl_f_reg <= scl_sy_reg[2];
			end
			if (sda_sy_reg[1] == sda_sy_reg[2]) begin
				sda_f_reg <= sda_sy_reg[2];
			end
			scl_d_reg <= scl_f_reg;
			sda_d_reg <= sda_f_reg;
		end
	end

	// Address strap, filtered the same way
	genvar gs;
	generate
		for (gs = 0; gs < 3; gs++) begin : g_sel
			always_ff @(posedge clk_link or negedge rstn_link) begin
				if (!rstn_link) begin
					sel_sy_reg[gs] <= 3'h0;
					sel_f_reg[gs] <= 1'b0;
				end else begin
					sel_sy_reg[gs] <= {sel_sy_reg[gs][1:0], address_select_pin[gs]};
					if (sel_sy_reg[gs][1] == sel_sy_reg[gs][2]) begin
						sel_f_reg[gs] <= sel_sy_reg[gs][2];
					end
				end
			end
		end
	endgenerate

	// Bus address follows the strap
	always_ff @(posedge clk_link or negedge rstn_link) begin
		if (!rstn_link) begin
			my_addr_reg <= odac_pkg::ADDR_BASE;
		end else begin
			my_addr_reg <= odac_pkg::ADDR_BASE + {4'h0, sel_f_reg};
		end
	end

	a_addr_sel: assert property (@(posedge clk_link) disable iff (!rstn_link)
		my_addr_reg[6:3] == 4'h9) else $error("bus address outside its group");

	assign scl_rise = scl_f_reg & ~scl_d_reg;
	assign scl_fall = ~scl_f_reg & scl_d_reg;
	assign start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
	assign stop_det = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

	// ==========================================================
	// Command decode
	assign rx_st = state_reg == odac_pkg::ST_ADDR || state_reg == odac_pkg::ST_CMD ||
		state_reg == odac_pkg::ST_MSB || state_reg == odac_pkg::ST_LSB;
	assign byte_done = scl_fall && !in_ack_reg && rx_st && cnt_reg == odac_pkg::BYTE_BITS;
	assign addr_hit = shift_reg[7:1] == my_addr_reg;
	assign is_pd = cmd_reg[7:4] == odac_pkg::CMD_PWRDN;
	assign is_wr = cmd_reg[7:4] <= odac_pkg::CMD_WR_LAST;
	assign rb_code = shadow_reg[cmd_reg[2:0]];

	// Channel nibble to mask; all-ones selects every channel
	always_comb begin
		wr_mask = 8'h00;
		if (cmd_reg[3:0] == odac_pkg::CH_ALL) begin
			wr_mask = 8'hFF;
		end else if (!cmd_reg[3]) begin
			wr_mask = 8'h01 << cmd_reg[2:0];
		end
	end

	// Power-down carries mode in bits 14:13 and a channel mask in 12:5
	assign push_mask = is_pd ? {msb_reg[4:0], shift_reg[7:5]} : wr_mask;
	assign push_code = is_pd ? {10'h000, msb_reg[6:5]} : {msb_reg, shift_reg[7:4]};
	assign push_fire = scl_fall && in_ack_reg && acked_reg && state_reg == odac_pkg::ST_LSB &&
		(is_pd || is_wr);
	assign wr_data = {is_pd, push_mask, push_code};

	// Read-back bytes: upper eight bits, then low nibble padded with zeros
	assign rd_byte = (state_reg == odac_pkg::ST_ADDR || rd_low_reg) ? rb_code[11:4] :
		{rb_code[3:0], 4'h0};

	// ==========================================================
	// Byte engine; starts and stops override everything
	always_ff @(posedge clk_link or negedge rstn_link) begin
		if (!rstn_link) begin
			state_reg <= odac_pkg::ST_IDLE;
			after_reg <= odac_pkg::ST_IDLE;
			in_ack_reg <= 1'b0;
			acked_reg <= 1'b0;
			oe_reg <= 1'b0;
			rd_low_reg <= 1'b0;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			msb_reg <= 8'h00;
			tx_reg <= 8'h00;
		end else if (start_det) begin
			// Start or repeated start keeps the command byte for read-back
			state_reg <= odac_pkg::ST_ADDR;
			in_ack_reg <= 1'b0;
			oe_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else if (stop_det) begin
			state_reg <= odac_pkg::ST_IDLE;
			in_ack_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (scl_rise && rx_st && !in_ack_reg) begin
			shift_reg <= {shift_reg[6:0], sda_f_reg};
			cnt_reg <= cnt_reg + 4'h1;
		end else if (scl_rise && in_ack_reg && state_reg == odac_pkg::ST_READ) begin
			acked_reg <= ~sda_f_reg; // Controller acknowledge
		end else if (byte_done) begin
			in_ack_reg <= 1'b1;
			cnt_reg <= 4'h0;
			case (state_reg)
				odac_pkg::ST_ADDR: begin
					// Foreign address or master code: stay silent to the next start
					acked_reg <= addr_hit;
					oe_reg <= addr_hit;
					if (!addr_hit) begin
						after_reg <= odac_pkg::ST_SKIP;
					end else if (shift_reg[0]) begin
						after_reg <= odac_pkg::ST_READ;
					end else begin
						after_reg <= odac_pkg::ST_CMD;
					end
				end
				odac_pkg::ST_CMD: begin
					acked_reg <= 1'b1;
					oe_reg <= 1'b1;
					cmd_reg <= shift_reg;
					after_reg <= odac_pkg::ST_MSB;
				end
				odac_pkg::ST_MSB: begin
					acked_reg <= 1'b1;
					oe_reg <= 1'b1;
					msb_reg <= shift_reg;
					after_reg <= odac_pkg::ST_LSB;
				end
				default: begin
					// Low byte: refused by not acknowledging when the queue is full
					acked_reg <= wr_ready;
					oe_reg <= wr_ready;
					after_reg <= wr_ready ? odac_pkg::ST_MSB : odac_pkg::ST_SKIP;
				end
			endcase
		end else if (scl_fall && in_ack_reg) begin
			// End of acknowledge; the update fires on this same edge
			in_ack_reg <= 1'b0;
			oe_reg <= 1'b0;
			cnt_reg <= 4'h0;
			if (after_reg == odac_pkg::ST_READ && (state_reg == odac_pkg::ST_ADDR || acked_reg)) begin
				state_reg <= odac_pkg::ST_READ;
				rd_low_reg <= state_reg == odac_pkg::ST_ADDR ? 1'b0 : ~rd_low_reg;
				oe_reg <= ~rd_byte[7];
				tx_reg <= {rd_byte[6:0], 1'b0};
				cnt_reg <= 4'h1;
			end else if (after_reg == odac_pkg::ST_READ) begin
				state_reg <= odac_pkg::ST_SKIP;
			end else begin
				state_reg <= after_reg;
			end
		end else if (scl_fall && state_reg == odac_pkg::ST_READ) begin
			if (cnt_reg == odac_pkg::BYTE_BITS) begin
				oe_reg <= 1'b0;
				in_ack_reg <= 1'b1;
				after_reg <= odac_pkg::ST_READ;
			end else begin
				oe_reg <= ~tx_reg[7];
				tx_reg <= {tx_reg[6:0], 1'b0};
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end

	// Open drain: only ever pulls low; the clock line has no driver at all
	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;

	a_addr_ack: assert property (@(posedge clk_link) disable iff (!rstn_link)
		byte_done && state_reg == odac_pkg::ST_ADDR && addr_hit && !shift_reg[0]
		|=> sda_oe && after_reg == odac_pkg::ST_CMD) else $error("own write address not acked");
	a_foreign_quiet: assert property (@(posedge clk_link) disable iff (!rstn_link)
		byte_done && state_reg == odac_pkg::ST_ADDR && !addr_hit
		|=> !sda_oe && after_reg == odac_pkg::ST_SKIP) else $error("foreign address answered");
	a_master_code: assert property (@(posedge clk_link) disable iff (!rstn_link)
		byte_done && state_reg == odac_pkg::ST_ADDR && shift_reg == odac_pkg::HS_MASTER_CODE
		|=> !sda_oe [*2]) else $error("master code acknowledged");
	a_rd_pad: assert property (@(posedge clk_link) disable iff (!rstn_link)
		scl_fall && state_reg == odac_pkg::ST_READ && !in_ack_reg && rd_low_reg &&
		cnt_reg >= odac_pkg::LOW_NIB_FIRST && cnt_reg < odac_pkg::BYTE_BITS
		|=> sda_oe) else $error("read-back pad nibble not zero");
	a_code_pack: assert property (@(posedge clk_link) disable iff (!rstn_link)
		push_fire && is_wr && push_mask[6]
		|=> shadow_reg[6][11:4] == $past(msb_reg) && shadow_reg[6][3:0] == $past(shift_reg[7:4]))
		else $error("code packed wrongly");
	a_pair_repeat: assert property (@(posedge clk_link) disable iff (!rstn_link)
		push_fire |=> state_reg == odac_pkg::ST_MSB && !in_ack_reg)
		else $error("no further data pair accepted");
	a_bcast_mask: assert property (@(posedge clk_link) disable iff (!rstn_link)
		push_fire && is_wr && cmd_reg[3:0] == odac_pkg::CH_ALL
		|-> wr_data[19:12] == 8'hFF) else $error("broadcast misses channels");

	// ==========================================================
	// Read-back shadow, written with each accepted code write, not with power-down
	genvar gc;
	generate
		for (gc = 0; gc < odac_pkg::CH_N; gc++) begin : g_shadow
			always_ff @(posedge clk_link or negedge rstn_link) begin
				if (!rstn_link) begin
					shadow_reg[gc] <= odac_pkg::CODE_RST;
				end else if (push_fire && is_wr && push_mask[gc]) begin
					shadow_reg[gc] <= push_code;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Crossing into the system domain
	odac_fifo #(.W(odac_pkg::FIFO_W), .DEPTH(odac_pkg::FIFO_DEPTH)) u_fifo (
		.wr_clk(clk_link),
		.wr_rstn(rstn_link),
		.wr_valid(push_fire),
		.wr_ready(wr_ready),
		.wr_data(wr_data),
		.rd_clk(clk_sys),
		.rd_rstn(rstn),
		.rd_valid(rd_valid),
		.rd_ready(rd_ready),
		.rd_data(rd_data)
	);

	// Update pin sampled like a bus pin; high holds updates in the queue
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			upd_sy_reg <= 3'h0;
			upd_f_reg <= 1'b0;
		end else begin
			upd_sy_reg <= {upd_sy_reg[1:0], output_update_pin};
			if (upd_sy_reg[1] == upd_sy_reg[2]) begin
				upd_f_reg <= upd_sy_reg[2];
			end
		end
	end
	assign rd_ready = ~upd_f_reg;
	assign pop = rd_valid & rd_ready;

	// Channel outputs, unsigned binary straight from the queue
	generate
		for (gc = 0; gc < odac_pkg::CH_N; gc++) begin : g_out
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					dac_code[gc] <= odac_pkg::CODE_RST;
					dac_pd_mode[gc] <= odac_pkg::PD_RST;
				end else if (pop && rd_data[odac_pkg::MASK_LSB + gc]) begin
					if (rd_data[odac_pkg::KIND_BIT]) begin
						dac_pd_mode[gc] <= rd_data[1:0];
					end else begin
						dac_code[gc] <= rd_data[11:0];
					end
				end
			end
		end
	endgenerate

	a_code_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
		pop && rd_data[odac_pkg::MASK_LSB] && !rd_data[odac_pkg::KIND_BIT]
		|=> dac_code[0] == $past(rd_data[11:0])) else $error("channel code not applied");
	a_sync_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		upd_f_reg |=> $stable(dac_code)) else $error("update while pin high");
endmodule

// *** rtl/odac_dummy_guard.sv ***
// No logic here; the command port and its queue share one design file

// *** tb/odac_ctl_model.sv ***
// Two-wire bus controller model that drives the serial clock and data
`timescale 1ns/1ps

// ==========================================================
// Controller model
module odac_ctl_model #(
	parameter int TH = 280,
	parameter int TS = 440,
	parameter int TP = 480
) (
	// Serial clock, never released high by anyone else
	output logic scl,
	// Data pull, high means released to the pull-up
	output logic sda_drv,
	// Resolved data wire
	input wire logic sda
);
	// Idle bus: both lines released high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One bit: data moves well after the fall, sampled mid-high
	// Long low phase leaves room for the target's filtered release of an ack
	task bitx(input logic b, output logic r);
		#TH;
		sda_drv = b;
		#TS;
		scl = 1'b1;
		#(TP / 2);
		r = sda;
		#(TP / 2);
		scl = 1'b0;
	endtask

	// Start or repeated start: data falls while clock is high
	task start();
		#TH;
		sda_drv = 1'b1;
		#TS;
		scl = 1'b1;
		#TP;
		sda_drv = 1'b0;
		#TP;
		scl = 1'b0;
	endtask

	// Stop: data rises while clock is high, bus left idle
	task stop();
		#TH;
		sda_drv = 1'b0;
		#TS;
		scl = 1'b1;
		#TP;
		sda_drv = 1'b1;
		#TP;
	endtask

	// Byte out, most significant bit first, ack read on the ninth clock
	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask

	// Byte in, then ack (low) or the final nack (high)
	task rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the two-wire command port
`timescale 1ns/1ps

module tb;
	// ==========================================================
	// Clocks, reset, pins and bookkeeping
	logic clk_sys, clk_link, rstn, scl, ctl_sda, sda_oe, sda_out, output_update_pin;
	logic [2:0] address_select_pin;
	logic [7:0][11:0] dac_code;
	logic [7:0][1:0] dac_pd_mode;
	logic sda_w;
	int num_errors, checks;
	logic [31:0] rnd;
	logic [11:0] exp_code [8];
	logic [7:0] b1, b2, msk;
	logic a;

	// Open-drain wire: pull-up unless a party pulls low
	assign sda_w = ctl_sda & (sda_oe ? sda_out : 1'b1);

	// System clock, 8 ns
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Oversampling clock, 80 ns, phase unrelated to the system clock
	initial begin
		clk_link = 1'b0;
		#13;
		forever #40 clk_link = ~clk_link;
	end

	// ==========================================================
	// Device and controller
	odac_i2c_port odac_i2c_port_i (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_select_pin(address_select_pin), .output_update_pin(output_update_pin),
		.dac_code(dac_code), .dac_pd_mode(dac_pd_mode));
	odac_ctl_model odac_ctl_model_i (.scl(scl), .sda_drv(ctl_sda), .sda(sda_w));

	// ==========================================================
	// Expectation helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Code is the upper byte plus the upper nibble of the lower byte
	function automatic logic [11:0] code_of(input logic [7:0] m, input logic [7:0] l);
		return {m, l[7:4]};
	endfunction
	// Channel mask of a power-down word, bit 0 is channel A
	function automatic logic [7:0] pd_mask(input logic [7:0] m, input logic [7:0] l);
		return {m[4:0], l[7:5]};
	endfunction

	// ==========================================================
	// Compare tasks
	task chk_code(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_all();
		for (int i = 0; i < 8; i++)
			chk_code("channel code", exp_code[i], dac_code[i]);
	endtask
	// Room for filter latency and the queue's clock crossing
	task settle();
		repeat (150) @(posedge clk_sys);
	endtask

	// ==========================================================
	// Bus sequences
	task open_w(input logic [7:0] ab, input logic [7:0] cmd);
		logic ak;
		odac_ctl_model_i.start();
		odac_ctl_model_i.wbyte(ab, ak);
		chk_byte("address ack", 8'h01, {7'h0, ak});
		odac_ctl_model_i.wbyte(cmd, ak);
		chk_byte("command ack", 8'h01, {7'h0, ak});
	endtask
	task pair(input logic [7:0] m, input logic [7:0] l, input logic e2);
		logic ak;
		odac_ctl_model_i.wbyte(m, ak);
		chk_byte("upper byte ack", 8'h01, {7'h0, ak});
		odac_ctl_model_i.wbyte(l, ak);
		chk_byte("lower byte ack", {7'h0, e2}, {7'h0, ak});
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard, above the expected run of about 710 us, below 100k system cycles
	initial begin
		#790000;
		num_errors++;
		$display("[ERR] run time expected finish seen timeout");
		final_report();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		address_select_pin = 3'h0;
		output_update_pin = 1'b0;
		rnd = 32'h0000004E;
		num_errors = 0;
		checks = 0;
		for (int i = 0; i < 8; i++)
			exp_code[i] = 12'h000;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		settle();
		chk_all();
		for (int i = 0; i < 8; i++)
			chk_byte("pd mode", 8'h00, {6'h0, dac_pd_mode[i]});
		chk_byte("data drive", 8'h00, {7'h0, sda_oe});
		$display("test reset done");
		// Every write command code, full and zero scale corners first
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			if (i == 0)
				rnd[15:0] = 16'hFFF3;
			if (i == 1)
				rnd[15:0] = 16'h000C;
			open_w(8'h90, {i[3:0], i[2:0], 1'b0});
			pair(rnd[15:8], rnd[7:0], 1'b1);
			odac_ctl_model_i.stop();
			exp_code[2 * i] = code_of(rnd[15:8], rnd[7:0]);
			settle();
			chk_all();
		end
		$display("test single writes done");
		// Two pairs in one transfer, each updates on its own
		open_w(8'h90, 8'h05);
		pair(8'hFF, 8'hFA, 1'b1);
		settle();
		exp_code[5] = 12'hFFF;
		chk_all();
		pair(8'h40, 8'h0C, 1'b1);
		odac_ctl_model_i.stop();
		settle();
		exp_code[5] = 12'h400;
		chk_all();
		$display("test repeated pairs done");
		// All channels at once, twice in one transfer
		open_w(8'h90, 8'h3F);
		pair(8'h80, 8'h07, 1'b1);
		settle();
		for (int i = 0; i < 8; i++)
			exp_code[i] = 12'h800;
		chk_all();
		rnd = xs(rnd);
		pair(rnd[15:8], rnd[7:0], 1'b1);
		odac_ctl_model_i.stop();
		settle();
		for (int i = 0; i < 8; i++)
			exp_code[i] = code_of(rnd[15:8], rnd[7:0]);
		chk_all();
		$display("test broadcast done");
		// Master code left unanswered, then read-back of channel G
		odac_ctl_model_i.start();
		odac_ctl_model_i.wbyte(8'h08, a);
		chk_byte("master code ack", 8'h00, {7'h0, a});
		open_w(8'h90, 8'h06);
		odac_ctl_model_i.start();
		odac_ctl_model_i.wbyte(8'h91, a);
		chk_byte("read address ack", 8'h01, {7'h0, a});
		odac_ctl_model_i.rbyte(1'b0, b1);
		odac_ctl_model_i.rbyte(1'b1, b2);
		odac_ctl_model_i.stop();
		chk_byte("read upper", exp_code[6][11:4], b1);
		chk_byte("read lower", {exp_code[6][3:0], 4'h0}, b2);
		$display("test read-back done");
		// Strap moves the address, the old one becomes foreign
		@(posedge clk_sys);
		address_select_pin <= 3'h1;
		settle();
		odac_ctl_model_i.start();
		odac_ctl_model_i.wbyte(8'h90, a);
		chk_byte("foreign address ack", 8'h00, {7'h0, a});
		odac_ctl_model_i.wbyte(8'h00, a);
		chk_byte("foreign command ack", 8'h00, {7'h0, a});
		odac_ctl_model_i.stop();
		rnd = xs(rnd);
		open_w(8'h92, 8'h07);
		pair(rnd[15:8], rnd[7:0], 1'b1);
		odac_ctl_model_i.stop();
		exp_code[7] = code_of(rnd[15:8], rnd[7:0]);
		settle();
		chk_all();
		@(posedge clk_sys);
		address_select_pin <= 3'h0;
		settle();
		$display("test addressing done");
		// Power-down of B, C and H with high impedance, codes untouched
		open_w(8'h90, 8'h4A);
		pair(8'h70, 8'hC3, 1'b1);
		odac_ctl_model_i.stop();
		settle();
		msk = pd_mask(8'h70, 8'hC3);
		for (int i = 0; i < 8; i++)
			chk_byte("pd mode", msk[i] ? 8'h03 : 8'h00, {6'h0, dac_pd_mode[i]});
		chk_all();
		$display("test power-down done");
		// Channel nibbles 8 to E select no channel: acked, nothing changes
		rnd = xs(rnd);
		open_w(8'h90, 8'h09);
		pair(rnd[15:8], rnd[7:0], 1'b1);
		odac_ctl_model_i.stop();
		settle();
		chk_all();
		$display("test no-channel write done");
		// Held updates fill the queue, the fifth lower byte is refused
		@(posedge clk_sys);
		output_update_pin <= 1'b1;
		open_w(8'h90, 8'h03);
		for (int k = 0; k < 4; k++) begin
			rnd = xs(rnd);
			pair(rnd[15:8], rnd[7:0], 1'b1);
		end
		pair(8'hAB, 8'hC0, 1'b0);
		odac_ctl_model_i.stop();
		settle();
		chk_all();
		@(posedge clk_sys);
		output_update_pin <= 1'b0;
		settle();
		exp_code[3] = code_of(rnd[15:8], rnd[7:0]);
		chk_all();
		$display("test queue done");
		final_report();
	end
endmodule
